// ==== core/bth_hdr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module bth_hdr_regs
    import bth_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CFG_WR_I,
    input  wire logic        CFG_RD_I,
    input  wire logic [5:0]  CFG_DW_ADDR_I,
    input  wire logic [3:0]  CFG_BE_I,
    input  wire logic [31:0] CFG_WDATA_I,
    output logic      [31:0] CFG_RDATA_O,
    output logic             CFG_ACK_O,
    input  wire logic        CONTROL_WINDOW_ENABLE_I,
    input  wire logic        SCRATCH_WINDOW_ENABLE_I,
    input  wire logic        MEM_REQ_I,
    input  wire logic [31:0] MEM_ADDR_I,
    output logic             MEM_DONE_O,
    output logic             CTRL_HIT_O,
    output logic             SCRATCH_HIT_O,
    input  wire logic        T1_REQ_I,
    input  wire logic [7:0]  T1_BUS_I,
    output logic             T1_DONE_O,
    output logic             T1_LOCAL_O,
    output logic             T1_UNSUP_O,
    output logic      [7:0]  UPSTREAM_BUS_O,
    output logic      [7:0]  DOWNSTREAM_BUS_O
);

    // address decode
    logic        sel_hdr0c;
    logic        sel_ctrl;
    logic        sel_scr;
    logic        sel_bus;
    logic        wr_ctrl;
    logic        wr_scr;
    logic        wr_bus;

    assign sel_hdr0c = (CFG_DW_ADDR_I == BTH_DW_HDR0C);
    assign sel_ctrl  = (CFG_DW_ADDR_I == BTH_DW_CTRL_WIN);
    assign sel_scr   = (CFG_DW_ADDR_I == BTH_DW_SCR_WIN);
    assign sel_bus   = (CFG_DW_ADDR_I == BTH_DW_BUSNUM);
    assign wr_ctrl   = CFG_WR_I & sel_ctrl;
    assign wr_scr    = CFG_WR_I & sel_scr;
    assign wr_bus    = CFG_WR_I & sel_bus;

    // bus number registers
    logic [7:0]  up_bus_q;
    logic [7:0]  up_bus_d;
    logic [7:0]  dn_bus_q;
    logic [7:0]  dn_bus_d;
    logic [31:0] bus_word;
    logic [31:0] bus_merged;

    always_comb begin
        bus_word = BTH_WORD_ZERO;
        bus_word[BTH_LANE_UP_BUS*8 +: 8] = up_bus_q;
        bus_word[BTH_LANE_DN_BUS*8 +: 8] = dn_bus_q;
    end

    assign bus_merged = bth_be_merge(bus_word, CFG_WDATA_I, CFG_BE_I);
    assign up_bus_d   = wr_bus ? bus_merged[BTH_LANE_UP_BUS*8 +: 8] : up_bus_q;
    assign dn_bus_d   = wr_bus ? bus_merged[BTH_LANE_DN_BUS*8 +: 8] : dn_bus_q;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            up_bus_q <= BTH_BUS_RST;
            dn_bus_q <= BTH_BUS_RST;
        end else begin
            up_bus_q <= up_bus_d;
            dn_bus_q <= dn_bus_d;
        end
    end

    // memory window base registers
    logic [19:0] ctrl_field;
    logic [31:0] ctrl_word;
    logic [19:0] scr_field;
    logic [31:0] scr_word;

    bth_win_reg u_ctrl_win (
        .clk_i   (CLK_I),
        .rst_i   (RESET_I),
        .en_i    (CONTROL_WINDOW_ENABLE_I),
        .wr_i    (wr_ctrl),
        .be_i    (CFG_BE_I),
        .wdata_i (CFG_WDATA_I),
        .field_o (ctrl_field),
        .word_o  (ctrl_word)
    );

    bth_win_reg u_scr_win (
        .clk_i   (CLK_I),
        .rst_i   (RESET_I),
        .en_i    (SCRATCH_WINDOW_ENABLE_I),
        .wr_i    (wr_scr),
        .be_i    (CFG_BE_I),
        .wdata_i (CFG_WDATA_I),
        .field_o (scr_field),
        .word_o  (scr_word)
    );

    // fixed header dword at 0Ch; cache line byte lives elsewhere and reads zero
    logic [31:0] hdr0c_word;

    always_comb begin
        hdr0c_word = BTH_WORD_ZERO;
        hdr0c_word[BTH_LANE_LATENCY*8 +: 8]  = BTH_LATENCY_VAL;
        hdr0c_word[BTH_LANE_HEADER*8 +: 8]   = BTH_HEADER_VAL;
        hdr0c_word[BTH_LANE_SELFTEST*8 +: 8] = BTH_SELFTEST_VAL;
    end

    // read selection; writes to fixed bytes just acknowledge
    logic [31:0] rd_word;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ack_q;

    assign rd_word = sel_hdr0c ? hdr0c_word :
                     sel_ctrl  ? ctrl_word  :
                     sel_scr   ? scr_word   :
                     sel_bus   ? bus_word   : BTH_WORD_ZERO;
    assign rdata_d = CFG_RD_I ? rd_word : BTH_WORD_ZERO;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rdata_q <= BTH_WORD_ZERO;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= CFG_RD_I | CFG_WR_I;
        end
    end

    // memory request decode against programmed windows
    logic ctrl_match;
    logic scr_match;
    logic mem_done_q;
    logic ctrl_hit_q;
    logic scr_hit_q;

    assign ctrl_match = CONTROL_WINDOW_ENABLE_I &
                        (MEM_ADDR_I[BTH_WIN_LSB +: BTH_WIN_W] == ctrl_field);
    assign scr_match  = SCRATCH_WINDOW_ENABLE_I &
                        (MEM_ADDR_I[BTH_WIN_LSB +: BTH_WIN_W] == scr_field);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            mem_done_q <= 1'b0;
            ctrl_hit_q <= 1'b0;
            scr_hit_q  <= 1'b0;
        end else begin
            mem_done_q <= MEM_REQ_I;
            ctrl_hit_q <= MEM_REQ_I & ctrl_match;
            scr_hit_q  <= MEM_REQ_I & scr_match;
        end
    end

    // type 1 configuration steering by downstream bus number
    bth_cfg1_route u_cfg1 (
        .clk_i    (CLK_I),
        .rst_i    (RESET_I),
        .req_i    (T1_REQ_I),
        .bus_i    (T1_BUS_I),
        .dn_bus_i (dn_bus_q),
        .done_o   (T1_DONE_O),
        .local_o  (T1_LOCAL_O),
        .unsup_o  (T1_UNSUP_O)
    );

    assign CFG_RDATA_O      = rdata_q;
    assign CFG_ACK_O        = ack_q;
    assign MEM_DONE_O       = mem_done_q;
    assign CTRL_HIT_O       = ctrl_hit_q;
    assign SCRATCH_HIT_O    = scr_hit_q;
    assign UPSTREAM_BUS_O   = up_bus_q;
    assign DOWNSTREAM_BUS_O = dn_bus_q;

endmodule // bth_hdr_regs
`default_nettype wire

// ==== core/bth_pkg.sv ====
package bth_pkg;

    // dword indices of the configuration header
    localparam logic [5:0]  BTH_DW_HDR0C     = 6'h03;
    localparam logic [5:0]  BTH_DW_CTRL_WIN  = 6'h04;
    localparam logic [5:0]  BTH_DW_SCR_WIN   = 6'h05;
    localparam logic [5:0]  BTH_DW_BUSNUM    = 6'h06;

    // byte offsets as printed
    localparam logic [7:0]  BTH_OFS_LATENCY  = 8'h0D;
    localparam logic [7:0]  BTH_OFS_HEADER   = 8'h0E;
    localparam logic [7:0]  BTH_OFS_SELFTEST = 8'h0F;
    localparam logic [7:0]  BTH_OFS_CTRL_WIN = 8'h10;
    localparam logic [7:0]  BTH_OFS_SCR_WIN  = 8'h14;
    localparam logic [7:0]  BTH_OFS_UP_BUS   = 8'h18;
    localparam logic [7:0]  BTH_OFS_DN_BUS   = 8'h19;

    // byte lanes within a dword
    localparam int          BTH_LANE_LATENCY  = 1;
    localparam int          BTH_LANE_HEADER   = 2;
    localparam int          BTH_LANE_SELFTEST = 3;
    localparam int          BTH_LANE_UP_BUS   = 0;
    localparam int          BTH_LANE_DN_BUS   = 1;

    // fixed read values
    localparam logic [7:0]  BTH_LATENCY_VAL  = 8'h00;
    localparam logic [7:0]  BTH_HEADER_VAL   = 8'h01;
    localparam logic [7:0]  BTH_SELFTEST_VAL = 8'h00;
    localparam logic [7:0]  BTH_BUS_RST      = 8'h00;
    localparam logic [7:0]  BTH_BYTE_ZERO    = 8'h00;
    localparam logic [31:0] BTH_WORD_ZERO    = 32'h0000_0000;

    // memory window layout
    localparam int          BTH_WIN_LSB      = 12;
    localparam int          BTH_WIN_W        = 20;
    localparam logic [19:0] BTH_WIN_RST      = 20'h0_0000;
    localparam logic [11:0] BTH_WIN_LOW_VAL  = 12'h000;

    // byte-enable merge of a write into a stored word
    function automatic logic [31:0] bth_be_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ==== core/bth_win_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module bth_win_reg
    import bth_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic        wr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    output logic      [19:0] field_o,
    output logic      [31:0] word_o
);

    logic [19:0] field_q;
    logic [19:0] field_d;
    logic [31:0] merged;
    logic [19:0] field_rd;

    assign merged  = bth_be_merge(word_o, wdata_i, be_i);
    // disabled field reads zero and drops writes
    assign field_d = !en_i ? BTH_WIN_RST :
                     wr_i  ? merged[BTH_WIN_LSB +: BTH_WIN_W] : field_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_q <= BTH_WIN_RST;
        end else begin
            field_q <= field_d;
        end
    end

    assign field_o = field_q; // 20-bit field, 4 KB window
    // low bits constant zero, memory, 32-bit, not prefetchable
    // disabled field reads zero in the very cycle the enable drops
    assign field_rd = en_i ? field_q : BTH_WIN_RST;
    assign word_o  = {field_rd, BTH_WIN_LOW_VAL};

endmodule // bth_win_reg
`default_nettype wire

// ==== core/bth_cfg1_route.sv ====
`timescale 1ns/1ps
`default_nettype none
module bth_cfg1_route
    import bth_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [7:0] dn_bus_i,
    output logic            done_o,
    output logic            local_o,
    output logic            unsup_o
);

    logic done_q;
    logic local_q;
    logic unsup_q;
    logic hit;

    // only the internal bus lies below, so secondary alone decides
    assign hit = (bus_i == dn_bus_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q  <= 1'b0;
            local_q <= 1'b0;
            unsup_q <= 1'b0;
        end else begin
            done_q  <= req_i;
            local_q <= req_i & hit;
            unsup_q <= req_i & ~hit;
        end
    end

    assign done_o  = done_q;
    assign local_o = local_q;
    assign unsup_o = unsup_q;

endmodule // bth_cfg1_route
`default_nettype wire

// ==== sim/bth_hdr_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module bth_hdr_regs_chk (
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    input wire logic        CFG_WR_I,
    input wire logic        CFG_RD_I,
    input wire logic [5:0]  CFG_DW_ADDR_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic        CFG_ACK_O,
    input wire logic        CONTROL_WINDOW_ENABLE_I,
    input wire logic        SCRATCH_WINDOW_ENABLE_I,
    input wire logic        MEM_REQ_I,
    input wire logic        MEM_DONE_O,
    input wire logic        CTRL_HIT_O,
    input wire logic        T1_REQ_I,
    input wire logic [7:0]  T1_BUS_I,
    input wire logic        T1_DONE_O,
    input wire logic        T1_LOCAL_O,
    input wire logic        T1_UNSUP_O,
    input wire logic [7:0]  DOWNSTREAM_BUS_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    a_ack_next: assert property ((CFG_RD_I || CFG_WR_I) |=> CFG_ACK_O)
        else $error("config access not acknowledged");
    a_ack_cause: assert property (CFG_ACK_O |-> $past(CFG_RD_I || CFG_WR_I))
        else $error("ack without access");
    a_fixed_bytes: assert property (
        CFG_RD_I && CFG_DW_ADDR_I == 6'h03 |=> CFG_RDATA_O == 32'h0001_0000)
        else $error("fixed header bytes wrong");
    a_win_low: assert property (
        CFG_RD_I && CFG_DW_ADDR_I[5:1] == 5'h02 |=> CFG_RDATA_O[11:0] == 12'h000)
        else $error("window low bits not zero");
    a_ctrl_off: assert property (
        CFG_RD_I && CFG_DW_ADDR_I == 6'h04 && !CONTROL_WINDOW_ENABLE_I |=> CFG_RDATA_O == 32'h0)
        else $error("disabled window not zero");
    a_scr_off: assert property (
        CFG_RD_I && CFG_DW_ADDR_I == 6'h05 && !SCRATCH_WINDOW_ENABLE_I |=> CFG_RDATA_O == 32'h0)
        else $error("disabled scratch window not zero");
    a_mem_done: assert property (MEM_REQ_I |=> MEM_DONE_O)
        else $error("memory decode late");
    a_hit_cause: assert property (CTRL_HIT_O |-> MEM_DONE_O && $past(CONTROL_WINDOW_ENABLE_I))
        else $error("hit on disabled window");
    a_t1_answer: assert property (
        T1_REQ_I |=> T1_DONE_O && T1_LOCAL_O == ($past(T1_BUS_I) == $past(DOWNSTREAM_BUS_O)))
        else $error("type 1 answer wrong");
    a_t1_excl: assert property (T1_DONE_O |-> T1_LOCAL_O ^ T1_UNSUP_O)
        else $error("type 1 flags not exclusive");

    c_hdr_read: cover property (CFG_ACK_O && CFG_RDATA_O == 32'h0001_0000);
    c_ctrl_hit: cover property (CTRL_HIT_O);
    c_t1_unsup: cover property (T1_UNSUP_O);
    c_scr_off:  cover property (CFG_RD_I && CFG_DW_ADDR_I == 6'h05 && !SCRATCH_WINDOW_ENABLE_I);
endmodule // bth_hdr_regs_chk
`default_nettype wire

// ==== sim/bth_rc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bth_rc_model (
    input  wire logic        clk_i,
    output logic             wr_o = 1'b0,
    output logic             rd_o = 1'b0,
    output logic      [5:0]  dw_o = 6'h00,
    output logic      [3:0]  be_o = 4'h0,
    output logic      [31:0] wd_o = 32'h0,
    input  wire logic [31:0] rd_data_i
);
    logic [7:0] sub_bus = 8'h00;

    task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        dw_o <= a;
        be_o <= b;
        wd_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        be_o <= ~b;
        wd_o <= ~d;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        dw_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        dw_o <= ~a;
        #1;
        d = rd_data_i;
    endtask

    // subordinate kept equal to downstream
    task automatic set_bus(input logic [7:0] u, input logic [7:0] d, input logic [15:0] h);
        wr(6'h06, 4'hF, {h, d, u});
        sub_bus = d;
    endtask
endmodule // bth_rc_model
`default_nettype wire

// ==== sim/tb_bth_hdr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_bth_hdr_regs;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b0, se = 1'b0, mreq = 1'b0, treq = 1'b0;
    logic        wr, rd, ack, mdone, chit, shit, tdone, tloc, tuns;
    logic [1:0]  en;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [7:0]  tbus = 8'h00, upb, dnb, u, d;
    logic [31:0] wd, rdata, a, v, r;
    logic [31:0] maddr = 32'h0;
    logic [31:0] win [2];
    int          seed = 74, fail_count = 0, check_count = 0;

    always #2 clk = ~clk;

    bth_rc_model rc_u (.clk_i(clk), .wr_o(wr), .rd_o(rd), .dw_o(dw), .be_o(be), .wd_o(wd),
        .rd_data_i(rdata));
    bth_hdr_regs dut_u (.CLK_I(clk), .RESET_I(rst), .CFG_WR_I(wr), .CFG_RD_I(rd),
        .CFG_DW_ADDR_I(dw), .CFG_BE_I(be), .CFG_WDATA_I(wd), .CFG_RDATA_O(rdata),
        .CFG_ACK_O(ack), .CONTROL_WINDOW_ENABLE_I(ce), .SCRATCH_WINDOW_ENABLE_I(se),
        .MEM_REQ_I(mreq), .MEM_ADDR_I(maddr), .MEM_DONE_O(mdone), .CTRL_HIT_O(chit),
        .SCRATCH_HIT_O(shit), .T1_REQ_I(treq), .T1_BUS_I(tbus), .T1_DONE_O(tdone),
        .T1_LOCAL_O(tloc), .T1_UNSUP_O(tuns), .UPSTREAM_BUS_O(upb), .DOWNSTREAM_BUS_O(dnb));

    function automatic logic [31:0] exp_win(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] b);
        logic [31:0] x;
        x = o;
        for (int i = 1; i < 4; i++) begin
            if (b[i]) begin
                x[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return {x[31:12], 12'h000};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rdc(input logic [5:0] x, input logic [31:0] exp);
        rc_u.rd(x, r);
        chk(r, exp);
    endtask

    task automatic mem(input logic [31:0] x, input logic c, input logic s);
        @(posedge clk);
        mreq <= 1'b1;
        maddr <= x;
        @(posedge clk);
        mreq <= 1'b0;
        #1;
        chk({29'h0, mdone, chit, shit}, {29'h0, 1'b1, c, s});
    endtask

    task automatic t1(input logic [7:0] b, input logic loc);
        @(posedge clk);
        treq <= 1'b1;
        tbus <= b;
        @(posedge clk);
        treq <= 1'b0;
        #1;
        chk({29'h0, tdone, tloc, tuns}, {29'h0, 1'b1, loc, ~loc});
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(6'h03, 32'h0001_0000);
        rdc(6'h05, 32'h0);
        rdc(6'h06, 32'h0);
        rc_u.wr(6'h03, 4'hF, 32'hFFFF_FFFF);
        rc_u.wr(6'h3F, 4'hF, 32'hFFFF_FFFF);
        rdc(6'h03, 32'h0001_0000);
        rdc(6'h3F, 32'h0);
        $display("test fixed bytes done");
        @(posedge clk);
        ce <= 1'b1;
        rc_u.wr(6'h04, 4'hF, 32'hFFFF_FFFF);
        rdc(6'h04, 32'hFFFF_F000);
        mem(32'hFFFF_F123, 1'b1, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        rc_u.wr(6'h04, 4'hF, 32'h1234_5000);
        @(posedge clk);
        ce <= 1'b1;
        rdc(6'h04, 32'h0);
        $display("test window enable done");
        win[0] = 32'h0;
        win[1] = 32'h0;
        for (int i = 0; i < 24; i++) begin
            v = $random(seed);
            r = $random(seed);
            en = {v[2] | v[3], v[0] | v[1]};
            @(posedge clk);
            ce <= en[0];
            se <= en[1];
            if (!en[0]) win[0] = 32'h0;
            if (!en[1]) win[1] = 32'h0;
            rc_u.wr({5'h02, v[4]}, v[11:8], r);
            if (en[v[4]]) win[v[4]] = exp_win(win[v[4]], r, v[11:8]);
            rdc(6'h04, win[0]);
            rdc(6'h05, win[1]);
            a = {win[v[4]][31:12] ^ {19'h0, v[24]}, v[23:12]};
            mem(a, en[0] && a[31:12] == win[0][31:12],
                en[1] && a[31:12] == win[1][31:12]);
        end
        $display("test window random done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            u = v[7:0];
            d = (i == 0) ? 8'hFF : v[15:8];
            rc_u.set_bus(u, d, v[31:16]);
            rdc(6'h06, {16'h0, d, u});
            chk({16'h0, dnb, upb}, {16'h0, d, u});
            t1(rc_u.sub_bus, 1'b1);
            t1(d ^ (v[23:16] | 8'h01), 1'b0);
        end
        $display("test bus numbers done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(6'h06, 32'h0);
        rdc(6'h05, 32'h0);
        chk({16'h0, dnb, upb}, 32'h0);
        $display("test mid reset done");
        give_verdict();
    end

    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
endmodule // tb_bth_hdr_regs

bind bth_hdr_regs bth_hdr_regs_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_DW_ADDR_I(CFG_DW_ADDR_I),
    .CFG_RDATA_O(CFG_RDATA_O), .CFG_ACK_O(CFG_ACK_O),
    .CONTROL_WINDOW_ENABLE_I(CONTROL_WINDOW_ENABLE_I),
    .SCRATCH_WINDOW_ENABLE_I(SCRATCH_WINDOW_ENABLE_I), .MEM_REQ_I(MEM_REQ_I),
    .MEM_DONE_O(MEM_DONE_O), .CTRL_HIT_O(CTRL_HIT_O), .T1_REQ_I(T1_REQ_I), .T1_BUS_I(T1_BUS_I),
    .T1_DONE_O(T1_DONE_O), .T1_LOCAL_O(T1_LOCAL_O), .T1_UNSUP_O(T1_UNSUP_O),
    .DOWNSTREAM_BUS_O(DOWNSTREAM_BUS_O));
`default_nettype wire
